/* File: src/pmseq_pkg.sv */
// Constants and types for the power-mode sequencer.
// Assumes a 100 MHz clock; analog comparators arrive as asynchronous levels.
package pmseq_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PULLDOWN_MS = 30;
  localparam int unsigned PULLDOWN_CYC = PULLDOWN_MS * (CLK_HZ / 1000);
  localparam int unsigned BOOT_MIN_MS = 80;
  localparam int unsigned BOOT_STEP_MS = 20;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned OCP_DEB_US = 100;
  localparam int unsigned OCP_DEB_CYC = OCP_DEB_US * (CLK_HZ / 1_000_000);
  localparam int unsigned N_REG = 8;
  localparam int unsigned N_GEN_IRQ = 4;
  localparam int unsigned N_HPT_IRQ = 3;
  localparam int unsigned N_IRQ = N_GEN_IRQ + N_HPT_IRQ;
  localparam int unsigned AON_IDX = 1;
  localparam logic [2:0] SEQ_IMMEDIATE = 3'h0;
  localparam logic [2:0] SEQ_ALWAYS_ON = 3'h1;
  localparam logic [2:0] SEQ_POINT_1 = 3'h2;
  localparam logic [2:0] SEQ_POINT_2 = 3'h3;
  localparam logic [2:0] SEQ_RELEASE = 3'h4;
  localparam logic [2:0] SEQ_MANUAL = 3'h7;
  localparam logic [4:0] BOOT_DELAY_MAX = 5'h11;
  typedef enum logic [2:0] {
    PMSEQ_SEAL = 3'b000, PMSEQ_OFF = 3'b001, PMSEQ_SEQ = 3'b011,
    PMSEQ_ON = 3'b010, PMSEQ_PULLDOWN = 3'b110, PMSEQ_RECOVERY = 3'b111
  } pmseq_mode_e;
  typedef struct packed {
    logic harvester_support_enable;
    logic system_node_pulldown_enable;
    logic sequence_retry_enable;
    logic [1:0] harvester_battery_path_cfg;
    logic harvester_thermal_enable;
    logic harvester_thermal_disable_cfg;
    logic [4:0] boot_delay_field;
  } pmseq_cfg_s;
  typedef struct packed {
    logic digital_core_supply;
    logic button_monitor;
    logic charger_monitor;
    logic fuel_gauge;
    logic thermistor_monitor;
  } pmseq_res_s;
endpackage : pmseq_pkg

/* File: src/pmseq_top.sv */
// Power-mode state machine, power-on sequencer, load switch and interrupt logic.
// Assumes comparators and harvester wake are asynchronous levels; host reads are
// one-cycle strobes from the serial-bus block on the same clock.
module pmseq_top
  import pmseq_pkg::*;
(
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_reset_n, // Async reset, active low
  input wire pmseq_cfg_s i_cfg, // Static configuration
  input wire logic [N_REG*3-1:0] i_aon_ldo_sequence_field, // Per-regulator slot, 3 bits each
  input wire logic [N_REG-1:0] i_host_reg_enable, // Host manual enables after release
  input wire logic i_power_on_event, // Button or insertion wake request
  input wire logic i_seal_request, // Host request to enter seal
  input wire logic i_off_request, // Host request to enter off
  input wire logic i_charger_input_valid, // Charger input valid (async)
  input wire logic i_system_uvlo, // System below undervoltage (async)
  input wire logic i_system_at_battery, // System sagged to battery level (async)
  input wire logic i_battery_ocp, // Battery above overcurrent (async)
  input wire logic i_thermistor_unsafe, // Thermistor out of bounds (async)
  input wire logic i_harvester_wake_input, // Harvester wake pin (async)
  input wire logic [N_IRQ*8-1:0] i_irq_event, // Status change pulses, 8 per register
  input wire logic [N_IRQ*8-1:0] i_irq_mask, // Mask bits, 1 masks
  input wire logic [N_IRQ-1:0] i_irq_read, // Read strobe per status register
  output logic [N_IRQ*8-1:0] o_irq_status, // Latched status
  output logic o_irq_out, // Open-drain interrupt, data always 0
  output logic o_irq_oe_n, // Low while pulling interrupt low
  output logic o_harvester_disable_output, // Open-drain high-side data
  output logic o_harvester_disable_oe_n, // Low while driving disable
  output logic o_reset_n, // System reset, active low
  output logic [N_REG-1:0] o_reg_enable, // Regulator enables
  output logic o_system_pulldown, // System node discharge switch
  output logic o_battery_switch_closed, // Battery-to-system switch
  output pmseq_res_s o_resources, // Per-mode resource enables
  output logic [1:0] o_harvester_path_mode, // Harvester path setting to power stage
  output logic [2:0] o_mode // Current mode code
);
  pmseq_mode_e mode;
  pmseq_mode_e next_mode;
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic chg_ok, uvlo, sys_at_bat, ocp, thm_bad, wake;
  logic [31:0] timer;
  logic [31:0] boot_cyc;
  logic [31:0] ocp_cnt;
  logic ocp_trip;
  logic aon_was_on;
  logic wake_d;

  // Decode one regulator's sequencing slot
  function automatic logic [2:0] slot(input logic [N_REG*3-1:0] f, input int unsigned i);
    slot = f[i*3 +: 3];
  endfunction : slot

  // Two-stage synchronisers for all asynchronous levels
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {i_charger_input_valid, i_system_uvlo, i_system_at_battery, i_battery_ocp,
                 i_thermistor_unsafe};
      sync_b <= sync_a;
    end
  end
  assign {chg_ok, uvlo, sys_at_bat, ocp, thm_bad} = sync_b;

  logic wake_a;
  logic wake_b;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_a <= 1'b0;
      wake_b <= 1'b0;
      wake_d <= 1'b0;
    end else begin
      wake_a <= i_harvester_wake_input;
      wake_b <= wake_a;
      wake_d <= wake_b;
    end
  end
  // Wake pin honoured only with harvester support
  assign wake = wake_b & ~wake_d & i_cfg.harvester_support_enable;

  always_comb begin
    logic [4:0] f;
    f = (i_cfg.boot_delay_field > BOOT_DELAY_MAX) ? BOOT_DELAY_MAX : i_cfg.boot_delay_field;
    boot_cyc = (BOOT_MIN_MS + 32'(f) * BOOT_STEP_MS) * MS_CYC;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ocp_cnt <= 32'h0;
    end else if (!ocp) begin
      ocp_cnt <= 32'h0;
    end else if (ocp_cnt <= OCP_DEB_CYC) begin
      ocp_cnt <= ocp_cnt + 32'h1;
    end
  end
  assign ocp_trip = (ocp_cnt > OCP_DEB_CYC);

  always_comb begin
    next_mode = mode;
    case (mode)
      PMSEQ_SEAL: begin
        if (i_power_on_event) begin
          next_mode = PMSEQ_SEQ;
        end
      end
      PMSEQ_OFF: begin
        if (i_seal_request) begin
          next_mode = PMSEQ_SEAL;
        end else if (i_cfg.harvester_support_enable) begin
          next_mode = i_cfg.system_node_pulldown_enable ? PMSEQ_PULLDOWN : PMSEQ_RECOVERY;
        end else if (i_power_on_event) begin
          next_mode = PMSEQ_SEQ;
        end
      end
      PMSEQ_PULLDOWN: begin
        if (timer >= PULLDOWN_CYC - 1) begin
          next_mode = PMSEQ_RECOVERY;
        end
      end
      PMSEQ_RECOVERY: begin
        if (wake || i_power_on_event) begin
          next_mode = PMSEQ_SEQ;
        end
      end
      PMSEQ_SEQ: begin
        if (ocp_trip) begin
          next_mode = PMSEQ_OFF;
        end else if (uvlo && !chg_ok) begin
          next_mode = PMSEQ_OFF;
        end else if (timer >= boot_cyc) begin
          next_mode = PMSEQ_ON;
        end
      end
      PMSEQ_ON: begin
        if (ocp_trip || i_off_request) begin
          next_mode = PMSEQ_OFF;
        end else if (i_seal_request) begin
          next_mode = PMSEQ_SEAL;
        end
      end
      default: next_mode = PMSEQ_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode <= PMSEQ_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // Sequencing and pulldown timer; restarts on every mode change
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer <= 32'h0;
    end else if (next_mode != mode) begin
      timer <= 32'h0;
    end else if (mode == PMSEQ_SEQ && uvlo && chg_ok && i_cfg.sequence_retry_enable) begin
      timer <= 32'h0;
    end else if (mode == PMSEQ_SEQ || mode == PMSEQ_PULLDOWN) begin
      timer <= timer + 32'h1;
    end
  end

  // Remember whether the always-on regulator was running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aon_was_on <= 1'b0;
    end else if (mode == PMSEQ_ON) begin
      aon_was_on <= o_reg_enable[AON_IDX];
    end else if (mode == PMSEQ_SEAL) begin
      aon_was_on <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_REG; g++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_reg_enable[g] <= 1'b0;
        end else begin
          case (mode)
            PMSEQ_SEQ: begin
              case (slot(i_aon_ldo_sequence_field, g))
                SEQ_IMMEDIATE, SEQ_ALWAYS_ON: o_reg_enable[g] <= 1'b1;
                SEQ_POINT_1: o_reg_enable[g] <= (timer >= boot_cyc / 3);
                SEQ_POINT_2: o_reg_enable[g] <= (timer >= (boot_cyc / 3) * 2);
                default: o_reg_enable[g] <= 1'b0;
              endcase
            end
            PMSEQ_ON: begin
              // Release-slot regulators switch on at release; host enables can turn on any regulator
              if (slot(i_aon_ldo_sequence_field, g) == SEQ_RELEASE && mode != next_mode) begin
                o_reg_enable[g] <= o_reg_enable[g];
              end else if (slot(i_aon_ldo_sequence_field, g) == SEQ_RELEASE
                           && !o_reset_n) begin
                o_reg_enable[g] <= 1'b1;
              end else if (i_host_reg_enable[g]) begin
                o_reg_enable[g] <= 1'b1;
              end
            end
            PMSEQ_OFF, PMSEQ_RECOVERY, PMSEQ_PULLDOWN: begin
              // Only the always-on regulator may stay up
              o_reg_enable[g] <= (g == AON_IDX) &&
                (aon_was_on || slot(i_aon_ldo_sequence_field, g) == SEQ_ALWAYS_ON);
            end
            default: o_reg_enable[g] <= 1'b0; // Seal turns all off
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reset_n <= 1'b0;
    end else begin
      o_reset_n <= (mode == PMSEQ_ON);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_resources <= '0;
    end else begin
      o_resources.button_monitor <= 1'b1;
      o_resources.charger_monitor <= 1'b1;
      o_resources.digital_core_supply <= (mode != PMSEQ_SEAL);
      o_resources.fuel_gauge <= (mode != PMSEQ_SEAL);
      o_resources.thermistor_monitor <= (mode == PMSEQ_RECOVERY) || (mode == PMSEQ_ON);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_system_pulldown <= 1'b0;
    end else begin
      o_system_pulldown <= (next_mode == PMSEQ_PULLDOWN);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_battery_switch_closed <= 1'b0;
    end else if (mode == PMSEQ_SEAL || mode == PMSEQ_PULLDOWN) begin
      o_battery_switch_closed <= 1'b0;
    end else if (mode == PMSEQ_RECOVERY) begin
      o_battery_switch_closed <= 1'b1;
    end else begin
      o_battery_switch_closed <= !chg_ok || sys_at_bat;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_harvester_disable_oe_n <= 1'b1;
    end else begin
      o_harvester_disable_oe_n <= !(i_cfg.harvester_support_enable && thm_bad &&
        (mode == PMSEQ_RECOVERY || (mode == PMSEQ_ON && i_cfg.harvester_thermal_enable
                                    && !i_cfg.harvester_thermal_disable_cfg)));
    end
  end
  assign o_harvester_disable_output = 1'b1;

  // Harvester path setting only in harvester on mode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_harvester_path_mode <= 2'h0;
    end else begin
      o_harvester_path_mode <= (mode == PMSEQ_ON && i_cfg.harvester_support_enable)
        ? i_cfg.harvester_battery_path_cfg : 2'h0;
    end
  end

  // Status latches; set wins over read clear
  generate
    for (g = 0; g < N_IRQ; g++) begin : g_irq
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_irq_status[g*8 +: 8] <= 8'h00;
        end else if (i_irq_read[g]) begin
          o_irq_status[g*8 +: 8] <= i_irq_event[g*8 +: 8];
        end else begin
          o_irq_status[g*8 +: 8] <= o_irq_status[g*8 +: 8] | i_irq_event[g*8 +: 8];
        end
      end
    end
  endgenerate

  // Interrupt low while any unmasked bit set
  assign o_irq_oe_n = ~|(o_irq_status & ~i_irq_mask);
  assign o_irq_out = 1'b0;
  assign o_mode = mode;

  uvlo_abort_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == PMSEQ_SEQ && uvlo && !chg_ok && !ocp_trip) |=> mode == PMSEQ_OFF)
    else $error("undervoltage did not abort");
  uvlo_retry_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == PMSEQ_SEQ && next_mode == PMSEQ_SEQ && uvlo && chg_ok
     && i_cfg.sequence_retry_enable) |=> timer == 32'h0)
    else $error("retry did not restart");
  // Overcurrent must end sequencing as well as on mode
  ocp_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((mode == PMSEQ_ON || mode == PMSEQ_SEQ) && ocp_trip) |=> mode == PMSEQ_OFF)
    else $error("overcurrent not shut off");
  seal_regs_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == PMSEQ_SEAL && $past(mode) == PMSEQ_SEAL) |-> o_reg_enable == '0)
    else $error("regulator on in seal");
  irq_drive_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (|(i_irq_event & ~i_irq_mask)) |=> !o_irq_oe_n)
    else $error("interrupt not asserted");
  irq_latch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_irq_event[0] && i_irq_mask[0]) |=> o_irq_status[0])
    else $error("masked status not latched");
  recov_switch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == PMSEQ_RECOVERY) ##1 (mode == PMSEQ_RECOVERY) |-> o_battery_switch_closed)
    else $error("switch open in recovery");
  wake_on_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == PMSEQ_RECOVERY && wake) |=> mode == PMSEQ_SEQ)
    else $error("wake ignored");
  // Any mode that follows the charger must open the switch while it is valid and the system has not sagged to battery
  chg_switch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode != PMSEQ_SEAL && mode != PMSEQ_PULLDOWN && mode != PMSEQ_RECOVERY
     && chg_ok && !sys_at_bat) |=> !o_battery_switch_closed)
    else $error("switch closed with charger");
  pulldown_span_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_system_pulldown == (mode == PMSEQ_PULLDOWN))
    else $error("discharge not aligned with pulldown");
endmodule : pmseq_top

/* File: bench/pmseq_partner.sv */
// Host and harvester model facing the sequencer.
// Assumes design outputs settle just after each rising edge of i_clk.
module pmseq_partner
  import pmseq_pkg::*;
(
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_service_en, // Host services interrupts
  input wire logic i_battery_ready, // Battery at harvester threshold
  input wire logic i_irq_oe_n, // Interrupt pulled low
  input wire logic [N_IRQ*8-1:0] i_irq_status, // Latched status
  input wire logic [N_IRQ*8-1:0] i_irq_mask, // Mask bits
  input wire logic i_disable_oe_n, // Harvester disable driven low
  input wire logic [2:0] i_mode, // Device mode code
  output logic [N_IRQ-1:0] o_irq_read, // Read strobes
  output logic o_wake // Harvester wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N_IRQ*8-1:0] pend;
  assign pend = i_irq_status & ~i_irq_mask;
  // read pending registers
  // One strobe per burst: status clears a cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_read <= '0;
    end else begin
      for (int g = 0; g < N_IRQ; g++) begin
        o_irq_read[g] <= i_service_en && !i_irq_oe_n && (pend[8*g +: 8] != 8'h00)
          && !o_irq_read[g];
      end
    end
  end
  // wake at threshold
  // Charging halts while the device drives disable
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_battery_ready && i_disable_oe_n && (i_mode == PMSEQ_RECOVERY);
    end
  end
endmodule : pmseq_partner

/* File: bench/pmseq_top_tb.sv */
// Self-checking bench for the power-mode sequencer.
// Assumes the partner model services interrupts and drives harvester wake.
module pmseq_top_tb
  import pmseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, rst_n, pon, seal, off_req, chg, uvlo, satb, ocp, battery_thermistor_input, svc, bready;
  logic wake, irq_out, irq_oe_n, hd_out, hd_oe_n, rst_out_n, pd, bsw;
  pmseq_cfg_s cfg;
  logic [N_REG*3-1:0] seqf;
  logic [N_REG-1:0] hen, ren;
  logic [N_IRQ*8-1:0] evt, msk, status;
  logic [N_IRQ-1:0] rd;
  pmseq_res_s res;
  logic [1:0] pmode;
  logic [2:0] mode;
  int failures;
  int checks;

  pmseq_top uut (.i_clk(i_clk), .i_reset_n(rst_n), .i_cfg(cfg),
    .i_aon_ldo_sequence_field(seqf), .i_host_reg_enable(hen), .i_power_on_event(pon),
    .i_seal_request(seal), .i_off_request(off_req), .i_charger_input_valid(chg),
    .i_system_uvlo(uvlo), .i_system_at_battery(satb), .i_battery_ocp(ocp),
    .i_thermistor_unsafe(battery_thermistor_input), .i_harvester_wake_input(wake), .i_irq_event(evt),
    .i_irq_mask(msk), .i_irq_read(rd), .o_irq_status(status), .o_irq_out(irq_out),
    .o_irq_oe_n(irq_oe_n), .o_harvester_disable_output(hd_out),
    .o_harvester_disable_oe_n(hd_oe_n), .o_reset_n(rst_out_n), .o_reg_enable(ren),
    .o_system_pulldown(pd), .o_battery_switch_closed(bsw), .o_resources(res),
    .o_harvester_path_mode(pmode), .o_mode(mode));

  pmseq_partner partner (.i_clk(i_clk), .i_reset_n(rst_n), .i_service_en(svc),
    .i_battery_ready(bready), .i_irq_oe_n(irq_oe_n), .i_irq_status(status),
    .i_irq_mask(msk), .i_disable_oe_n(hd_oe_n), .i_mode(mode), .o_irq_read(rd),
    .o_wake(wake));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Sample 1 ns after the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic do_reset(input logic harv, input logic pdn);
    @(posedge i_clk);
    rst_n <= 1'b0;
    cfg.harvester_support_enable <= harv;
    cfg.system_node_pulldown_enable <= pdn;
    repeat (2) @(posedge i_clk);
    rst_n <= 1'b1;
    cyc(3);
  endtask : do_reset

  task automatic t_off();
    chk(mode, PMSEQ_OFF, "off mode");
    chk(res, 5'h1E, "off resources");
    chk(ren, 64'(1) << AON_IDX, "off regulators");
    chk(hd_oe_n, 1'b1, "no disable without harvester");
  endtask : t_off

  task automatic t_seal();
    @(posedge i_clk) seal <= 1'b1;
    @(posedge i_clk) seal <= 1'b0;
    cyc(3);
    chk(mode, PMSEQ_SEAL, "seal mode");
    chk(res, 5'h0C, "seal resources");
    chk(ren, 8'h00, "seal regulators");
  endtask : t_seal

  task automatic t_seq();
    @(posedge i_clk) pon <= 1'b1;
    @(posedge i_clk) pon <= 0;
    cyc(3);
    chk(mode, PMSEQ_SEQ, "sequencing");
    chk(ren, 8'hF2, "immediate slots only");
    chk(rst_out_n, 1'b0, "reset held in boot delay");
    chk(bsw, 1'b1, "switch closed, no charger");
    @(posedge i_clk) chg <= 1'b1;
    cyc(4);
    chk(bsw, 1'b0, "switch open with charger");
    @(posedge i_clk) satb <= 1'b1;
    cyc(4);
    chk(bsw, 1'b1, "switch closed at sag");
    @(posedge i_clk) satb <= 1'b0;
    uvlo <= 1'b1;
    cyc(5);
    chk(mode, PMSEQ_SEQ, "retry keeps sequencing");
    @(posedge i_clk) uvlo <= 1'b0;
    chg <= 1'b0;
    cyc(4);
    @(posedge i_clk) uvlo <= 1'b1;
    cyc(5);
    chk(mode, PMSEQ_OFF, "undervoltage without charger");
    @(posedge i_clk) uvlo <= 1'b0;
  endtask : t_seq

  task automatic t_ocp();
    @(posedge i_clk) pon <= 1'b1;
    @(posedge i_clk) pon <= 0;
    cyc(3);
    @(posedge i_clk) ocp <= 1'b1;
    cyc(OCP_DEB_CYC - 10);
    chk(mode, PMSEQ_SEQ, "short overcurrent ignored");
    cyc(30);
    chk(mode, PMSEQ_OFF, "sustained overcurrent");
    @(posedge i_clk) ocp <= 1'b0;
  endtask : t_ocp

  task automatic t_irq();
    svc <= 1'b1;
    for (int g = 0; g < N_IRQ; g++) begin
      @(posedge i_clk) msk <= {N_IRQ*8{1'b1}} ^ ((N_IRQ*8)'(2) << (8*g));
      @(posedge i_clk) evt <= (N_IRQ*8)'(1) << (8*g);
      @(posedge i_clk) evt <= '0;
      #1;
      chk(status[8*g +: 8], 8'h01, "masked bit latched");
      chk(irq_oe_n, 1'b1, "masked bit quiet");
      chk(irq_out, 1'b0, "interrupt data pulls low");
      @(posedge i_clk) evt <= (N_IRQ*8)'(2) << (8*g);
      @(posedge i_clk) evt <= '0;
      #1;
      chk(irq_oe_n, 1'b0, "unmasked bit drives low");
      cyc(4);
      chk(irq_oe_n, 1'b1, "released after read");
      chk(status[8*g +: 8], 8'h00, "cleared on read");
    end
  endtask : t_irq

  task automatic t_harv();
    do_reset(1'b1, 1'b1);
    chk(mode, PMSEQ_PULLDOWN, "pulldown first");
    chk(pd, 1'b1, "system node discharging");
    cyc(100);
    chk(mode, PMSEQ_PULLDOWN, "pulldown still timing");
    do_reset(1'b1, 1'b0);
    chk(mode, PMSEQ_RECOVERY, "battery recovery");
    chk(bsw, 1'b1, "recovery switch closed");
    chk(res, 5'h1F, "recovery resources");
    chk(pmode, 2'h0, "no harvester path outside on");
    chk(hd_out, 1'b1, "disable high-side data");
    chk(hd_oe_n, 1'b1, "disable idle");
    @(posedge i_clk) battery_thermistor_input <= 1'b1;
    cyc(4);
    chk(hd_oe_n, 1'b0, "unsafe temperature disables");
    @(posedge i_clk) battery_thermistor_input <= 1'b0;
    cyc(4);
    chk(hd_oe_n, 1'b1, "disable released");
    @(posedge i_clk) bready <= 1'b1;
    cyc(7);
    chk(mode, PMSEQ_SEQ, "wake leaves recovery");
  endtask : t_harv

  // Scenarios need about 10k cycles; allow roughly three times that
  initial begin
    #300_000;
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    cfg = '0;
    cfg.sequence_retry_enable = 1'b1;
    cfg.harvester_battery_path_cfg = 2'h3;
    seqf = 24'h00050F;
    {hen, pon, seal, off_req, chg, uvlo, satb, ocp, battery_thermistor_input, svc, bready} = '0;
    evt = '0;
    msk = '1;
    do_reset(1'b0, 1'b0);
    t_off();
    t_irq();
    t_seal();
    t_seq();
    t_ocp();
    t_harv();
    stop_test();
  end
endmodule : pmseq_top_tb
